// File: ctm_core.v
// Notes on behaviour
// RULE1 - Two interrupt sources: period match and compare-register match.
// RULE2 - A match event can clear the counter and change the output pin.
// RULE3 - External clock pin counts only when selected, on chosen edge.
// RULE4 - Compare output mode drives pin high, low or toggles on match.
// RULE5 - Output pin carries the PWM waveform in PWM mode. Code does so only for action 10; 00 and 01 give a fixed level, 11 holds.
// RULE6 - One enable bit per pin hands it to the timer.
// RULE7 - Small variant enables at bits 5, 4 and 0; rest read zero.
// RULE8 - Large variant enables at bits 7, 5, 4, 1, 0; 7, 4, 0 reset one.
// RULE9 - Software never enables more than one capture input at once.
// RULE10 - Second output pin is same or inverted signal, per port bit.
// RULE11 - Low byte compare write only loads the shared holding buffer.
// RULE12 - High byte write updates high bits and copies buffer to low.
// RULE13 - High byte read returns high bits and captures low into buffer.
// RULE14 - Low byte read returns the holding buffer.
// RULE15 - Software writes low before high, reads high before low.
// RULE16 - Ten-bit up-counter from internal clock or external pin.
// RULE17 - Period compares top three bits; compare value all ten bits.
// RULE18 - No counter write path; only clear on on/off rising.
// RULE19 - Counter clears on overflow or comparator match, raising events.
// RULE20 - Compare output, timer/counter and PWM modes.
// RULE21 - Clock select codes; 101 disables; 110 rising, 111 falling pin.
// RULE22 - Period in 128-clock steps; 000 means full 1024 clocks.
// RULE23 - On/off rising clears counter; falling stops and holds value.
// RULE24 - Mode field: 00 compare, 10 PWM, 11 timer; 01 undefined.
// RULE25 - Counter keeps running while its low byte is captured.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ctm_defs.vh"

module ctm_core
#(
   parameter LARGE_VARIANT = 0
)
(
   input wire clk, // 50 MHz system clock
   input wire rst_n, // Async reset, active low
   input wire [4:0] avs_address, // Word index
   input wire avs_read, // Read request
   input wire avs_write, // Write request
   input wire [31:0] avs_writedata, // Write data, low byte used
   output reg [31:0] avs_readdata, // Read data
   output wire avs_waitrequest, // Stall
   input wire tbc_tick, // Time-base clock tick, same domain
   input wire timer_ext_clock_pin, // External clock pin, async
   input wire port_invert, // Port data bit inverting second output
   output reg timer_output_pin0, // First output pin level
   output wire timer_output_pin0_oe, // First output enable
   output reg timer_output_pin1, // Second output pin level
   output wire timer_output_pin1_oe, // Second output enable
   output wire [7:0] timer_pin_select, // Pin-select register view
   output reg match_p_pulse, // Period match event
   output reg match_a_pulse // Compare match event
);

   localparam [7:0] PSEL_MASK = LARGE_VARIANT ? `CTM_PSEL_MASK_L : `CTM_PSEL_MASK_S;
   localparam [7:0] PSEL_RST = LARGE_VARIANT ? `CTM_PSEL_RST_L : `CTM_PSEL_RST_S;

   reg [7:0] ctrl0_reg;
   reg [7:0] ctrl1_reg;
   reg [7:0] psel_reg;
   reg [7:0] buf_reg;
   reg [9:0] cmpa_reg;
   reg [9:0] cnt_reg;
   reg [1:0] status_reg;
   reg ack_reg;
   reg on_prev_reg;
   reg [5:0] div_reg;
   reg ext_s1_reg;
   reg ext_s2_reg;
   reg ext_s3_reg;
   reg out_reg;
   reg tick;
   reg [7:0] rd_next;

   wire req = avs_read | avs_write;
   wire take = req & ack_reg;
   wire [2:0] idx = avs_address[2:0];
   wire hit = (avs_address[4:3] == 2'h0);
   wire [7:0] wd = avs_writedata[7:0];
   wire [2:0] cks = ctrl0_reg[`CTM_C0_CKS_HI:`CTM_C0_CKS_LO];
   wire [2:0] per = ctrl0_reg[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
   wire on_bit = ctrl0_reg[`CTM_C0_ON];
   wire [1:0] mode = ctrl1_reg[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
   wire [1:0] io = ctrl1_reg[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
   wire oc = ctrl1_reg[`CTM_C1_OC];
   wire on_rise = on_bit & ~on_prev_reg;
   wire run = on_bit & ~ctrl0_reg[`CTM_C0_PAUSE] & tick;
   wire [9:0] nxt = cnt_reg + 10'h001;

   //------------------------------------------------------------
   // Bus slave
   //------------------------------------------------------------

   // One wait cycle; a write acts at the edge with waitrequest low, a read one edge earlier
   assign avs_waitrequest = req & ~ack_reg;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= req & ~ack_reg;
   end

   // Read mux; unmapped words read zero
   always @*
   begin
      rd_next = 8'h00;
      if (hit)
      begin
         case (idx)
            `CTM_IDX_CTRL0: rd_next = ctrl0_reg;
            `CTM_IDX_CTRL1: rd_next = ctrl1_reg;
            // RULE14 - low reads buffer
            `CTM_IDX_CNT_L: rd_next = buf_reg;
            `CTM_IDX_CMPA_L: rd_next = buf_reg;
            // RULE13 - high bits direct
            `CTM_IDX_CNT_H: rd_next = {6'h00, cnt_reg[9:8]};
            `CTM_IDX_CMPA_H: rd_next = {6'h00, cmpa_reg[9:8]};
            // RULE7 - unused bits zero
            `CTM_IDX_PINSEL: rd_next = psel_reg & PSEL_MASK;
            `CTM_IDX_STATUS: rd_next = {6'h00, status_reg};
            default: rd_next = 8'h00;
         endcase
      end
   end

   // Data is latched in the wait cycle, so it stands at the taking edge
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h00000000;
      else if (avs_read & ~ack_reg)
         avs_readdata <= {24'h000000, rd_next};
   end

   // Control and pin-select registers
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl0_reg <= 8'h00;
         ctrl1_reg <= 8'h00;
         // RULE8 - variant reset values
         psel_reg <= PSEL_RST;
      end
      else if (take & avs_write & hit)
      begin
         if (idx == `CTM_IDX_CTRL0)
            ctrl0_reg <= wd;
         if (idx == `CTM_IDX_CTRL1)
            ctrl1_reg <= wd;
         // RULE7 - only mapped bits stored
         if (idx == `CTM_IDX_PINSEL)
            psel_reg <= wd & PSEL_MASK;
      end
   end

   // Shared holding buffer and compare value
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_reg <= 8'h00;
         cmpa_reg <= 10'h000;
      end
      else if (hit)
      begin
         // RULE11 - low write to buffer
         if (take & avs_write & (idx == `CTM_IDX_CMPA_L))
            buf_reg <= wd;
         // RULE12 - high write merges buffer
         if (take & avs_write & (idx == `CTM_IDX_CMPA_H))
            cmpa_reg <= {wd[1:0], buf_reg};
         // RULE13 - high read captures low
         // RULE25 - same edge as high bits, so a running count stays consistent
         if (avs_read & ~ack_reg & (idx == `CTM_IDX_CNT_H))
            buf_reg <= cnt_reg[7:0];
         if (avs_read & ~ack_reg & (idx == `CTM_IDX_CMPA_H))
            buf_reg <= cmpa_reg[7:0];
      end
   end

   //------------------------------------------------------------
   // Clock source
   //------------------------------------------------------------

   // Pin synchroniser; third stage only for edge detection
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
      end
      else
      begin
         ext_s1_reg <= timer_ext_clock_pin;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
      end
   end

   // Free prescaler; high clock taken equal to system clock
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         div_reg <= 6'h00;
      else
         div_reg <= div_reg + 6'h01;
   end

   // RULE21 - clock select decode
   always @*
   begin
      case (cks)
         `CTM_CKS_SYS4: tick = (div_reg[1:0] == 2'h3);
         `CTM_CKS_SYS: tick = 1'b1;
         `CTM_CKS_H16: tick = (div_reg[3:0] == 4'hF);
         `CTM_CKS_H64: tick = (div_reg == 6'h3F);
         `CTM_CKS_TBC: tick = tbc_tick;
         // RULE3 - pin used only when selected
         `CTM_CKS_EXTR: tick = ext_s2_reg & ~ext_s3_reg;
         `CTM_CKS_EXTF: tick = ~ext_s2_reg & ext_s3_reg;
         default: tick = 1'b0;
      endcase
   end

   //------------------------------------------------------------
   // Counter and comparators
   //------------------------------------------------------------

   // RULE17 - period on top bits
   wire hit_p = (per == 3'h0) ? (cnt_reg == `CTM_CNT_MAX) :
      ((nxt[9:7] == per) & (nxt[6:0] == 7'h00));
   // RULE17 - compare on all bits
   wire hit_a = (nxt == cmpa_reg);
   // RULE2 - match selects clearing
   wire clr = ctrl1_reg[`CTM_C1_CCLR] ? hit_a : hit_p;

   // RULE16 - ten-bit up counter
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= 10'h000;
         on_prev_reg <= 1'b0;
      end
      else
      begin
         on_prev_reg <= on_bit;
         // RULE18 - only software clear
         // RULE23 - rise clears, off holds
         if (on_rise)
            cnt_reg <= 10'h000;
         // RULE25 - counting ignores bus reads
         else if (run)
         begin
            // RULE19 - clear on overflow or match
            // RULE22 - zero period wraps at max
            if (clr)
               cnt_reg <= 10'h000;
            else
               cnt_reg <= nxt;
         end
      end
   end

   // RULE1 - two event sources
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         match_p_pulse <= 1'b0;
         match_a_pulse <= 1'b0;
      end
      else
      begin
         match_p_pulse <= run & ~on_rise & hit_p;
         match_a_pulse <= run & ~on_rise & hit_a;
      end
   end

   // Sticky flags, write one to clear; a new event beats the clear
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         status_reg <= 2'h0;
      else
      begin
         if (take & avs_write & hit & (idx == `CTM_IDX_STATUS))
            status_reg <= status_reg & ~wd[1:0];
         if (match_a_pulse)
            status_reg[`CTM_ST_A] <= 1'b1;
         if (match_p_pulse)
            status_reg[`CTM_ST_P] <= 1'b1;
      end
   end

   //------------------------------------------------------------
   // Output stage
   //------------------------------------------------------------

   // RULE20 - mode dependent output
   // RULE24 - undefined mode holds pin
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         out_reg <= 1'b0;
      else if (mode == `CTM_MODE_CMP)
      begin
         if (on_rise)
            out_reg <= oc;
         // RULE4 - match action
         else if (match_a_pulse)
         begin
            case (io)
               `CTM_IO_LOW: out_reg <= 1'b0;
               `CTM_IO_HIGH: out_reg <= 1'b1;
               `CTM_IO_TOG: out_reg <= ~out_reg;
               default: out_reg <= out_reg;
            endcase
         end
      end
      else if (mode == `CTM_MODE_PWM)
      begin
         // RULE5 - PWM waveform, duty from compare, only for action 10; 00 and 01 drive a fixed level, 11 holds
         case (io)
            `CTM_IO_NONE: out_reg <= ~oc;
            `CTM_IO_LOW: out_reg <= oc;
            `CTM_IO_HIGH: out_reg <= (cnt_reg < cmpa_reg) ? oc : ~oc;
            default: out_reg <= out_reg;
         endcase
      end
   end

   // RULE10 - second pin same or inverse
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer_output_pin0 <= 1'b0;
         timer_output_pin1 <= 1'b0;
      end
      else
      begin
         timer_output_pin0 <= out_reg ^ ctrl1_reg[`CTM_C1_POL];
         timer_output_pin1 <= out_reg ^ ctrl1_reg[`CTM_C1_POL] ^ port_invert;
      end
   end

   // RULE6 - one enable bit per pin
   // Timer-mode output stays off, as the pin control must be disabled there
   assign timer_output_pin0_oe = psel_reg[0] & (mode != `CTM_MODE_TMR);
   assign timer_output_pin1_oe = psel_reg[1] & (mode != `CTM_MODE_TMR);
   assign timer_pin_select = psel_reg & PSEL_MASK;

endmodule

// File: ctm_core_assertions.sv
`timescale 1ns/1ps
`include "ctm_defs.vh"
// --------------------------------
// Bus, pin-select and output checks
// --------------------------------
module ctm_core_chk
#(
   parameter LARGE_VARIANT = 0
)
(
   input wire clk, // Clock
   input wire rst_n, // Reset
   input wire [4:0] avs_address, // Index
   input wire avs_read, // Read
   input wire avs_write, // Write
   input wire [31:0] avs_writedata, // Data in
   input wire [31:0] avs_readdata, // Data out
   input wire avs_waitrequest, // Stall
   input wire port_invert, // Invert
   input wire timer_output_pin0, // Pin 0
   input wire timer_output_pin0_oe, // Enable 0
   input wire timer_output_pin1, // Pin 1
   input wire timer_output_pin1_oe, // Enable 1
   input wire [7:0] timer_pin_select, // Pin select
   input wire match_p_pulse, // Period event
   input wire match_a_pulse // Compare event
);
   localparam [7:0] MASK = LARGE_VARIANT ? `CTM_PSEL_MASK_L : `CTM_PSEL_MASK_S;
   localparam [7:0] RSTV = LARGE_VARIANT ? `CTM_PSEL_RST_L : `CTM_PSEL_RST_S;
   // Accepted transfer and unmapped index
   wire acc = !avs_waitrequest;
   wire unmap = avs_address[4:3] != 2'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> acc)
      else $error("more than one wait cycle");
   rd_upper_a: assert property (acc && avs_read |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   unmap_rd_a: assert property (acc && avs_read && unmap |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   unmap_wr_a: assert property (acc && avs_write && unmap |=> $stable(timer_pin_select))
      else $error("unmapped write changed pin select");
   psel_wr_a: assert property (acc && avs_write && avs_address == 5'h6 |=>
      timer_pin_select == ($past(avs_writedata[7:0]) & MASK)) else $error("pin select write");
   psel_rsv_a: assert property ((timer_pin_select & ~MASK) == 8'h0)
      else $error("reserved pin select bit set");
   psel_rst_a: assert property ($rose(rst_n) |-> timer_pin_select == RSTV)
      else $error("pin select reset value");
   oe_gate_a: assert property (!timer_pin_select[0] |-> !timer_output_pin0_oe)
      else $error("pin driven while not handed over");
   oe1_gate_a: assert property (!timer_pin_select[1] |-> !timer_output_pin1_oe)
      else $error("second pin driven while not handed over");
   p_pulse_a: assert property (match_p_pulse |=> !match_p_pulse)
      else $error("period event longer than a cycle");
   pin_pair_a: assert property ($past(rst_n) |->
      timer_output_pin1 == (timer_output_pin0 ^ $past(port_invert))) else $error("pin pair");
   cover property (match_a_pulse);
   cover property (match_p_pulse);
   cover property (acc && avs_write && avs_address == 5'h5);
endmodule

bind ctm_core ctm_core_chk #(.LARGE_VARIANT(LARGE_VARIANT)) ctm_core_chk_inst (
   .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .port_invert(port_invert),
   .timer_output_pin0(timer_output_pin0), .timer_output_pin0_oe(timer_output_pin0_oe),
   .timer_output_pin1(timer_output_pin1), .timer_output_pin1_oe(timer_output_pin1_oe),
   .timer_pin_select(timer_pin_select), .match_p_pulse(match_p_pulse),
   .match_a_pulse(match_a_pulse)
);

// File: ctm_defs.vh
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH
// Register word indices; byte address is four times the index
`define CTM_IDX_CTRL0 3'h0
`define CTM_IDX_CTRL1 3'h1
`define CTM_IDX_CNT_L 3'h2
`define CTM_IDX_CNT_H 3'h3
`define CTM_IDX_CMPA_L 3'h4
`define CTM_IDX_CMPA_H 3'h5
`define CTM_IDX_PINSEL 3'h6
`define CTM_IDX_STATUS 3'h7
// Control 0 fields
`define CTM_C0_PAUSE 7
`define CTM_C0_CKS_HI 6
`define CTM_C0_CKS_LO 4
`define CTM_C0_ON 3
`define CTM_C0_PER_HI 2
`define CTM_C0_PER_LO 0
// Control 1 fields
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_IO_HI 5
`define CTM_C1_IO_LO 4
`define CTM_C1_OC 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0
// Modes
`define CTM_MODE_CMP 2'h0
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TMR 2'h3
// Output actions
`define CTM_IO_NONE 2'h0
`define CTM_IO_LOW 2'h1
`define CTM_IO_HIGH 2'h2
`define CTM_IO_TOG 2'h3
// Clock select codes
`define CTM_CKS_SYS4 3'h0
`define CTM_CKS_SYS 3'h1
`define CTM_CKS_H16 3'h2
`define CTM_CKS_H64 3'h3
`define CTM_CKS_TBC 3'h4
`define CTM_CKS_EXTR 3'h6
`define CTM_CKS_EXTF 3'h7
// Pin select masks and reset values per variant
`define CTM_PSEL_MASK_S 8'h31
`define CTM_PSEL_RST_S 8'h11
`define CTM_PSEL_MASK_L 8'hB3
`define CTM_PSEL_RST_L 8'h91
// Status flags
`define CTM_ST_A 0
`define CTM_ST_P 1
`define CTM_CNT_MAX 10'h3FF
`endif

// File: ctm_ext_model.sv
`timescale 1ns/1ps
// --------------------------------
// External clock source
// --------------------------------
module ctm_ext_model
(
   input wire clk, // System clock
   input wire run, // Edges allowed
   input wire [7:0] half, // Half period in clocks
   output wire pin // External clock pin
);
   reg pin_reg = 1'b0;
   reg [7:0] cnt_reg = 8'h0;
   assign pin = pin_reg;
   // edge source
   // Idles low while stopped so no stray edge reaches the counter
   always @(posedge clk)
   begin
      cnt_reg <= (!run || cnt_reg + 8'h1 >= half) ? 8'h0 : cnt_reg + 8'h1;
      pin_reg <= run && (cnt_reg + 8'h1 >= half) ? ~pin_reg : pin_reg && run;
   end
endmodule

// File: test_compact_timer_module_core.sv
`timescale 1ns/1ps
`include "ctm_defs.vh"
// --------------------------------
// Stimulus and checks
// --------------------------------
module test_compact_timer_module_core;
   reg clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   reg tbc_tick = 1'b0, port_invert = 1'b0, ext_run = 1'b0;
   reg [4:0] avs_address = 5'h0;
   reg [31:0] avs_writedata = 32'h0, seed = 32'hED22;
   reg [7:0] ext_half = 8'h3, q, h;
   reg [9:0] v1, v2;
   integer n_mismatch = 0, checked = 0, cyc = 0, a_last = 0, a_gap = 0, p_last = 0, p_gap = 0;
   integer i, n, d;
   wire [31:0] rdata;
   wire wreq, pin0, pin0_oe, ext_pin, mp, ma, pin1_oe_l;
   wire [7:0] psel_l;
   localparam [47:0] CT = {8'h21, 8'h19, 8'h09, 8'h80, 8'h90, 8'hC0};
   localparam [5:0] CP = 6'b101100;
   ctm_core ctm_core_inst (
      .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .tbc_tick(tbc_tick), .timer_ext_clock_pin(ext_pin),
      .port_invert(port_invert), .timer_output_pin0(pin0), .timer_output_pin0_oe(pin0_oe),
      .timer_output_pin1(), .timer_output_pin1_oe(), .timer_pin_select(),
      .match_p_pulse(mp), .match_a_pulse(ma)
   );
   ctm_ext_model ctm_ext_model_inst (.clk(clk), .run(ext_run), .half(ext_half), .pin(ext_pin));
   // Large variant on the same bus; only its pin-select side is watched
   ctm_core #(.LARGE_VARIANT(1)) ctm_core_large_inst (
      .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(),
      .avs_waitrequest(), .tbc_tick(tbc_tick), .timer_ext_clock_pin(ext_pin),
      .port_invert(port_invert), .timer_output_pin0(), .timer_output_pin0_oe(),
      .timer_output_pin1(), .timer_output_pin1_oe(pin1_oe_l), .timer_pin_select(psel_l),
      .match_p_pulse(), .match_a_pulse()
   );
   function [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
   endfunction
   // Clocks per counter tick for each clock-select code but 101, which never ticks
   function integer div(input [2:0] c);
      case (c)
         3'h0: div = 4;
         3'h1: div = 1;
         3'h2: div = 16;
         3'h3: div = 64;
         3'h4: div = 10;
         default: div = 2 * ext_half;
      endcase
   endfunction
   task final_report;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      checked = checked + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Request held until the edge that sees the stall low
   task bus(input w, input [4:0] a, input [7:0] dat);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, dat};
      @(posedge clk);
      while (wreq !== 1'b0)
         @(posedge clk);
      q = rdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task rd16(input [4:0] hi, output [9:0] v);
      bus(0, hi, 0);
      h = q;
      bus(0, hi - 5'h1, 0);
      v = {h[1:0], q};
      chk(h[7:2], 0);
   endtask
   task wr16(input [4:0] hi, input [9:0] v);
      bus(1, hi - 5'h1, v[7:0]);
      bus(1, hi, {6'h0, v[9:8]});
   endtask
   // Off, set mode, then on so the counter restarts from zero
   task run(input [2:0] cks, input [2:0] per, input [7:0] c1);
      bus(1, `CTM_IDX_CTRL0, {1'b0, cks, 1'b0, per});
      bus(1, `CTM_IDX_CTRL1, c1);
      bus(1, `CTM_IDX_CTRL0, {1'b0, cks, 1'b1, per});
   endtask
   initial
      forever #10 clk = ~clk;
   // Cycle count, time-base tick, random invert bit and hang limit
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      tbc_tick <= cyc % 10 == 9;
      port_invert <= seed[cyc % 32];
      if (cyc == 60000)
      begin
         n_mismatch = n_mismatch + 1;
         final_report;
      end
   end
   // Spacing of successive events
   always @(posedge clk)
      if (ma === 1'b1)
         {a_gap, a_last} <= {cyc - a_last, cyc};
   always @(posedge clk)
      if (mp === 1'b1)
         {p_gap, p_last} <= {cyc - p_last, cyc};
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, `CTM_IDX_PINSEL, 0);
      chk(q, `CTM_PSEL_RST_S);
      chk(psel_l, `CTM_PSEL_RST_L);
      bus(1, `CTM_IDX_PINSEL, 8'hFF);
      bus(1, 5'h1F, 8'h00);
      bus(0, `CTM_IDX_PINSEL, 0);
      chk(q, `CTM_PSEL_MASK_S);
      chk(psel_l, `CTM_PSEL_MASK_L);
      chk(pin1_oe_l, 1);
      bus(0, 5'h1F, 0);
      chk(q, 0);
      bus(1, `CTM_IDX_PINSEL, 8'h00);
      #1 chk(pin0_oe, 0);
      chk(pin1_oe_l, 0);
      // one timer pin handed over at a time
      bus(1, `CTM_IDX_PINSEL, 8'h01);
      #1 chk(pin0_oe, 1);
      $display("pin select test done");
      n = xs();
      bus(1, `CTM_IDX_CMPA_L, n[7:0]);
      rd16(`CTM_IDX_CMPA_H, v1);
      chk(v1, 0);
      bus(1, `CTM_IDX_CMPA_H, {6'h0, n[9:8]});
      rd16(`CTM_IDX_CMPA_H, v1);
      chk(v1, {n[9:8], 8'h00});
      wr16(`CTM_IDX_CMPA_H, n[9:0]);
      rd16(`CTM_IDX_CMPA_H, v1);
      chk(v1, n[9:0]);
      $display("buffer test done");
      run(3'h5, 3'h0, 8'h00);
      repeat (50) @(posedge clk);
      rd16(`CTM_IDX_CNT_H, v1);
      chk(v1, 0);
      run(3'h1, 3'h0, 8'h00);
      repeat (200) @(posedge clk);
      // Many pairs so the reads straddle low-byte wraps at 256 and 512
      for (i = 0; i < 40; i = i + 1)
      begin
         rd16(`CTM_IDX_CNT_H, v1);
         rd16(`CTM_IDX_CNT_H, v2);
         chk(v2 - v1 < 10'd16 && v2 != v1, 1);
      end
      bus(1, `CTM_IDX_CTRL0, 8'h10);
      rd16(`CTM_IDX_CNT_H, v1);
      bus(1, `CTM_IDX_CNT_L, 8'h55);
      bus(1, `CTM_IDX_CNT_H, 8'h03);
      rd16(`CTM_IDX_CNT_H, v2);
      chk(v2, v1);
      bus(1, `CTM_IDX_CTRL0, 8'h18);
      rd16(`CTM_IDX_CNT_H, v2);
      chk(v2 < 10'd16, 1);
      $display("counter test done");
      ext_half <= 2 + xs() % 6;
      for (i = 0; i < 8; i = i + 1)
         if (i != 5)
         begin
            n = 2 + xs() % 20;
            wr16(`CTM_IDX_CMPA_H, n[9:0]);
            ext_run <= i > 5;
            run(i[2:0], 3'h0, 8'h31);
            d = div(i[2:0]) * n;
            repeat (3 * d + 20) @(posedge clk);
            chk(a_gap, d);
         end
      $display("clock source test done");
      for (i = 0; i < 8; i = i + 1)
      begin
         run(3'h1, i[2:0], 8'h30);
         d = (i == 0) ? 1024 : 128 * i;
         repeat (3 * d + 20) @(posedge clk);
         chk(p_gap, d);
      end
      // Both flags stick; stop first so no new event beats the clear
      bus(0, `CTM_IDX_STATUS, 0);
      chk(q, 8'h03);
      bus(1, `CTM_IDX_CTRL0, 8'h17);
      bus(1, `CTM_IDX_STATUS, 8'h03);
      bus(0, `CTM_IDX_STATUS, 0);
      chk(q, 0);
      $display("period test done");
      wr16(`CTM_IDX_CMPA_H, 10'd10);
      for (i = 0; i < 6; i = i + 1)
      begin
         run(3'h1, 3'h0, CT[47 - 8 * i -: 8]);
         repeat (50) @(posedge clk);
         #1 chk(pin0_oe, i < 5);
         if (i < 5)
            chk(pin0, CP[5 - i]);
      end
      $display("output test done");
      final_report;
   end
endmodule
